//--- logic/ott_overcurrent_trip_timing.sv
// overcurrent trip timing element with wishbone register access
// assumes phasor and voltage inputs synchronous to clk_i, one new value per cycle
//
// Function
// - between pickup and forty times nominal, delay follows the chosen curve
// - offer R, moderate, very, extreme inverse and four thermal curves
// - reset by characteristic, after a fixed delay, or instantly
// - thermal trip time is 5 times multiplier times K^M over (I/In)^M
// - K is 3 for phase current and 1 for ground current
// - slope M is 0, 1, 2 or 4 for flat, linear, square, fourth power
// - nominal current is 1 A or 5 A from the secondary rating
// - current clamps at 40 In; pickup below 0.02 In is refused
// - thermal reset delay is 5 K^2 times the multiplier (45 for phase, 5 for ground current), current independent
// - voltage restraint lowers pickup from the selected phase voltage
// - effective pickup is percentage times setting, never below the minimum
// - percentage 25 at quarter of max voltage, 100 at max, linear between
// - restraint changes only the pickup, never the curve shapes
// - with supervision on, breaker trip blocks the restrained element
// - nominal voltage is rating over root three only when both line to ground
// - line to line wiring forces line to line measuring mode
// - negative sequence selector evaluates negative sequence current instead
// - negative sequence is one third of IL1 plus a^2 IL2 plus a IL3
// - negative sequence element uses the same settings as phase element
module ott_overcurrent_trip_timing
  import ott_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // measurements
  input  wire logic signed [15:0] ia_re_i,
  input  wire logic signed [15:0] ia_im_i,
  input  wire logic signed [15:0] ib_re_i,
  input  wire logic signed [15:0] ib_im_i,
  input  wire logic signed [15:0] ic_re_i,
  input  wire logic signed [15:0] ic_im_i,
  input  wire logic        [15:0] ie_mag_i,
  input  wire logic        [15:0] v_lg_i,
  input  wire logic        [15:0] v_ll_i,
  input  wire logic               mcb_trip_i,
  // decisions
  output logic                    pickup_o,
  output logic                    trip_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] mag(input logic signed [15:0] re,
                                      input logic signed [15:0] im);
    logic [16:0] ar;
    logic [16:0] ai;
    logic [16:0] mx;
    logic [16:0] mn;
    logic [17:0] s;
    ar = re[15] ? 17'(-18'(re)) : 17'(re);
    ai = im[15] ? 17'(-18'(im)) : 17'(im);
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    // max plus 3/8 min: cheap magnitude, within a few percent
    s  = 18'(mx) + 18'(mn >> 2) + 18'(mn >> 3);
    return (s > 18'h0FFFF) ? 16'hFFFF : s[15:0];
  endfunction

  function automatic logic signed [15:0] seq(input logic signed [15:0] p,
                                             input logic signed [15:0] q,
                                             input logic signed [15:0] r,
                                             input logic signed [17:0] d);
    logic signed [39:0] t;
    t = 40'(p) - ((40'(q) + 40'(r)) >>> 1);
    // constants made signed, else the products go unsigned and lose the sign
    t = t + ((40'(d) * $signed(40'(SQRT3_2_Q16))) >>> 16);
    t = (t * $signed(40'(THIRD_Q16))) >>> 16;
    return t[15:0];
  endfunction

  function automatic logic [63:0] pow_m(input logic [15:0] x, input logic [2:0] m);
    logic [63:0] p;
    p = 64'h1;
    for (int i = 0; i < 4; i++)
    begin
      if (i < int'(m))
        p = p * 64'(x);
    end
    return p;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] sel);
    return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q, pickup_q, tmult_q, rdelay_q, vsec_q;
  logic [15:0] cur_q, volt_q;
  logic        mcb_q;
  logic        ack_q;
  logic [31:0] dat_q;
  ott_state_t  st_q, st_d;
  logic [23:0] elapsed_q, rcnt_q;
  logic        pick_q, trip_q;

  wire         req      = wb_cyc_i && wb_stb_i && !ack_q;
  wire         wr       = req && wb_we_i;
  wire [15:0]  wdat     = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire         wr_ctrl  = wr && (wb_adr_i == OFS_CTRL);
  wire         wr_pick  = wr && (wb_adr_i == OFS_PICKUP);
  wire         wr_tm    = wr && (wb_adr_i == OFS_TMULT);
  wire         wr_rdel  = wr && (wb_adr_i == OFS_RDELAY);
  wire         wr_vsec  = wr && (wb_adr_i == OFS_VSEC);
  wire         cmd_rst  = wr && (wb_adr_i == OFS_CMD) && wb_sel_i[0] && wb_dat_i[0];
  wire [15:0]  pick_new = merge16(pickup_q, wb_dat_i[15:0], wb_sel_i[1:0]);

  // control decode
  wire         en       = ctrl_q[CF_EN];
  wire [1:0]   qty      = ctrl_q[CF_QTY +: 2];
  wire         vrest    = ctrl_q[CF_VREST];
  wire         wire_ll  = ctrl_q[CF_WIRE];
  wire         ct5      = ctrl_q[CF_CT5];
  wire         vts      = ctrl_q[CF_VTS];
  wire [2:0]   curve    = ctrl_q[CF_CURVE +: 3];
  wire [1:0]   rmode    = ctrl_q[CF_RMODE +: 2];
  wire         thermal  = curve[2];

  // nominal current from the secondary rating
  wire [15:0]  i_nom    = ct5 ? IN_5A : IN_1A;
  wire [15:0]  p_min    = 16'(32'(i_nom) * PICKUP_MIN_PCT / 100);
  // breaker trip blocks the restrained element under supervision
  wire         blocked  = vrest && vts && mcb_q;
  wire [3:0]   status   = {st_q == OTT_RESET, blocked, trip_q, pick_q};

  wire [31:0]  rd_data  =
    (wb_adr_i == OFS_CTRL)    ? {16'h0000, ctrl_q}   :
    (wb_adr_i == OFS_PICKUP)  ? {16'h0000, pickup_q} :
    (wb_adr_i == OFS_TMULT)   ? {16'h0000, tmult_q}  :
    (wb_adr_i == OFS_RDELAY)  ? {16'h0000, rdelay_q} :
    (wb_adr_i == OFS_VSEC)    ? {16'h0000, vsec_q}   :
    (wb_adr_i == OFS_STATUS)  ? {28'h0000000, status} :
    (wb_adr_i == OFS_ELAPSED) ? {8'h00, elapsed_q}   : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      dat_q <= req ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= CTRL_RST;
      pickup_q <= PICKUP_RST;
      tmult_q  <= TMULT_RST;
      rdelay_q <= RDELAY_RST;
      vsec_q   <= VSEC_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= merge16(ctrl_q, wdat, wb_sel_i[1:0]);
      // refuse a pickup below the minimum
      if (wr_pick && pick_new >= p_min)
        pickup_q <= pick_new;
      if (wr_tm)
        tmult_q <= merge16(tmult_q, wdat, wb_sel_i[1:0]);
      if (wr_rdel)
        rdelay_q <= merge16(rdelay_q, wdat, wb_sel_i[1:0]);
      if (wr_vsec)
        vsec_q <= merge16(vsec_q, wdat, wb_sel_i[1:0]);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ---------------------------------------------------------------
  // measured quantity
  // ---------------------------------------------------------------
  // symmetrical component, a = -1/2 + j root3/2
  wire signed [15:0] i2_re = seq(ia_re_i, ib_re_i, ic_re_i, 18'(ib_im_i) - 18'(ic_im_i));
  wire signed [15:0] i2_im = seq(ia_im_i, ib_im_i, ic_im_i, 18'(ic_re_i) - 18'(ib_re_i));
  wire [15:0] m_a  = mag(ia_re_i, ia_im_i);
  wire [15:0] m_b  = mag(ib_re_i, ib_im_i);
  wire [15:0] m_c  = mag(ic_re_i, ic_im_i);
  wire [15:0] m_ab = (m_a > m_b) ? m_a : m_b;
  wire [15:0] m_ph = (m_ab > m_c) ? m_ab : m_c;
  // negative sequence replaces phase, same settings downstream
  wire [15:0] m_sel = (qty == OTT_Q_NEGSEQ) ? mag(i2_re, i2_im) :
                      (qty == OTT_Q_GROUND) ? ie_mag_i : m_ph;
  // dynamic range ends at forty times nominal
  wire [15:0] i_max = 16'(32'(i_nom) * DYN_RANGE);
  wire [15:0] i_clp = (m_sel > i_max) ? i_max : m_sel;
  // line to line wiring forces line to line measuring
  wire        meas_ll = wire_ll || ctrl_q[CF_MODE];
  wire [15:0] v_sel   = meas_ll ? v_ll_i : v_lg_i;

  // one pipeline stage keeps the magnitude logic off the compare path
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_q  <= 16'h0000;
      volt_q <= 16'h0000;
      mcb_q  <= 1'b0;
    end
    else
    begin
      cur_q  <= i_clp;
      volt_q <= v_sel;
      mcb_q  <= mcb_trip_i;
    end
  end

  // ---------------------------------------------------------------
  // effective pickup with voltage restraint
  // ---------------------------------------------------------------
  // rating over root three only for line to ground on both settings
  wire [15:0] v_nom = meas_ll ? vsec_q : 16'((33'(vsec_q) * 33'(NOMV_LG_Q16)) >> 16);
  // percentage is V over Vmax, clamped between 0.25 Vmax and Vmax
  wire [15:0] v_min = v_nom >> 2;
  wire [15:0] v_cl  = (volt_q <= v_min) ? v_min : (volt_q >= v_nom) ? v_nom : volt_q;
  // only the threshold moves, curves stay as they are
  wire [15:0] v_use = vrest ? v_cl : v_nom;
  // scaled by nominal voltage so no division is needed
  wire [39:0] ps_raw = 40'(pickup_q) * 40'(v_use);
  wire [39:0] ps_min = 40'(p_min) * 40'(v_nom);
  wire [39:0] ps     = (ps_raw < ps_min) ? ps_min : ps_raw;
  wire [39:0] is     = 40'(cur_q) * 40'(v_nom);
  // pick up above the effective threshold
  wire        pick    = en && (is > ps) && !blocked;

  // ---------------------------------------------------------------
  // characteristic evaluation
  // ---------------------------------------------------------------
  wire [7:0] ge;
  for (genvar b = 0; b < 8; b++)
  begin : g_mult
    assign ge[b] = 48'(is) >= 48'(MULT[b]) * 48'(ps);
  end
  // below twice pickup the 2x entry is used: a trade of accuracy for table size
  wire [2:0] bkt = ge[7] ? 3'h7 : ge[6] ? 3'h6 : ge[5] ? 3'h5 : ge[4] ? 3'h4 :
                   ge[3] ? 3'h3 : ge[2] ? 3'h2 : ge[1] ? 3'h1 : 3'h0;
  // inverse curves from the table, scaled by the multiplier
  wire        due_inv = 32'(elapsed_q) * 32'(TM_SCALE) >=
                        32'(INV_MS[{curve[1:0], bkt}]) * 32'(tmult_q);
  wire [15:0] k_val  = (qty == OTT_Q_GROUND) ? 16'(K_GROUND) : 16'(K_PHASE);
  wire [2:0]  m_exp  = (curve == OTT_FLAT_THERMAL_CURVE)   ? 3'h0 :
                       (curve == OTT_LINEAR_THERMAL_CURVE) ? 3'h1 :
                       (curve == OTT_SQUARE_THERMAL_CURVE) ? 3'h2 : 3'h4;
  // t*(I)^M >= 5*tm*K^M*In^M, ms and multiplier units folded in
  wire [95:0] th_lhs = 96'(elapsed_q) * 96'(pow_m(cur_q, m_exp));
  wire [95:0] th_rhs = 96'(THERM_C_S * MS_PER_S / TM_SCALE) * 96'(tmult_q) *
                       96'(pow_m(k_val, m_exp)) * 96'(pow_m(i_nom, m_exp));
  wire        due    = thermal ? (th_lhs >= th_rhs) : due_inv;

  // thermal reset 5*K^2 times the multiplier, 45 for phase current
  wire [39:0] rs_th  = 40'(THERM_C_S * MS_PER_S) * 40'(k_val) * 40'(k_val) * 40'(tmult_q);
  wire [39:0] rs_inv = 40'(TAU_MS[curve[1:0]]) * 40'(tmult_q);
  wire [39:0] rs_lhs = 40'(rcnt_q) * 40'(TM_SCALE);
  // reset by characteristic or by fixed delay
  wire        rdone  = (rmode == OTT_RST_DELAY) ? (rcnt_q >= 24'(rdelay_q)) :
                       (rs_lhs >= (thermal ? rs_th : rs_inv));
  wire        inst   = (rmode == OTT_RST_INST);

  // ---------------------------------------------------------------
  // millisecond tick
  // ---------------------------------------------------------------
  logic [15:0] tcnt_q;
  wire         tick = (tcnt_q == 16'(TICK_CYC - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tcnt_q <= 16'h0000;
    else
      tcnt_q <= tcnt_q + 16'h0001;
  end

  // ---------------------------------------------------------------
  // delay timer
  // ---------------------------------------------------------------
  // start on pickup, trip on expiry, reset per selected behaviour
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      OTT_IDLE:   if (pick) st_d = OTT_TIMING;
      OTT_TIMING: if (!pick) st_d = inst ? OTT_IDLE : OTT_RESET;
                  else if (due) st_d = OTT_TRIP;
      OTT_TRIP:   if (!pick) st_d = inst ? OTT_IDLE : OTT_RESET;
      OTT_RESET:  if (pick) st_d = OTT_TIMING;
                  else if (rdone) st_d = OTT_IDLE;
      default:    st_d = OTT_IDLE;
    endcase
    if (!en || cmd_rst)
      st_d = OTT_IDLE;
  end

  wire         run      = (st_q == OTT_TIMING) && pick && tick && (elapsed_q != 24'hFFFFFF);
  wire         rrun     = (st_q == OTT_RESET) && tick && (rcnt_q != 24'hFFFFFF);
  // unless reset is instant, elapsed time survives a short dropout and resumes from there
  wire [23:0]  elapsed_d = (st_d == OTT_IDLE) ? 24'h000000 :
                           run ? elapsed_q + 24'h000001 : elapsed_q;
  wire [23:0]  rcnt_d    = (st_d != OTT_RESET || st_q != OTT_RESET) ? 24'h000000 :
                           rrun ? rcnt_q + 24'h000001 : rcnt_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q      <= OTT_IDLE;
      elapsed_q <= 24'h000000;
      rcnt_q    <= 24'h000000;
      pick_q    <= 1'b0;
      trip_q    <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      elapsed_q <= elapsed_d;
      rcnt_q    <= rcnt_d;
      pick_q    <= pick;
      trip_q    <= (st_d == OTT_TRIP);
    end
  end

  assign pickup_o = pick_q;
  assign trip_o   = trip_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_wb_ack_once: assert property (s_wb_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_pickup_floor: assert property (wr_pick && pick_new < p_min |=> $stable(pickup_q))
    else $error("pickup below minimum accepted");
  a_restraint_min: assert property (vrest && volt_q <= v_min |-> ps >= ps_min && ps_raw == 40'(pickup_q) * 40'(v_nom >> 2))
    else $error("effective pickup under minimum");
  a_restraint_pct: assert property (vrest && volt_q >= v_nom |-> ps_raw == 40'(pickup_q) * 40'(v_nom))
    else $error("full voltage does not give full pickup");
  a_mcb_block: assert property ((vrest && vts && mcb_trip_i) ##1 (vrest && vts) |=> !pickup_o)
    else $error("restrained element not blocked");
  a_trip_cause: assert property ($rose(trip_o) |-> $past(st_q == OTT_TIMING && due && pick))
    else $error("trip without expired timer");
  a_inst_reset: assert property (st_q == OTT_TRIP && !pick && inst && en |=> st_q == OTT_IDLE && elapsed_q == 24'h000000 && !trip_o)
    else $error("instant reset not immediate");
  a_flat_delay: assert property (thermal && m_exp == 3'h0 |-> due == (32'(elapsed_q) >= 32'(tmult_q) * 32'h32))
    else $error("flat curve delay wrong");
  a_therm_reset: assert property (thermal && qty == OTT_Q_PHASE |-> rs_th == 40'(tmult_q) * 40'h0AFC8)
    else $error("thermal reset not 45 times multiplier");
  a_timer_step: assert property (st_q == OTT_TIMING && st_d == OTT_TIMING && run |=> elapsed_q == $past(elapsed_q) + 24'h000001)
    else $error("timer did not advance");

endmodule

//--- logic/ott_pkg.sv
// constants, field layout and types of the overcurrent trip timing block
// assumes a 40 MHz system clock and current magnitudes in units of 10 mA
package ott_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_PER_S      = 1000;
  localparam int TM_SCALE      = 100;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PICKUP  = 8'h04;
  localparam logic [7:0] OFS_TMULT   = 8'h08;
  localparam logic [7:0] OFS_RDELAY  = 8'h0C;
  localparam logic [7:0] OFS_VSEC    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_ELAPSED = 8'h18;
  localparam logic [7:0] OFS_CMD     = 8'h1C;

  // control fields
  localparam int CF_EN    = 0;
  localparam int CF_QTY   = 1;
  localparam int CF_VREST = 3;
  localparam int CF_MODE  = 4;
  localparam int CF_WIRE  = 5;
  localparam int CF_CT5   = 6;
  localparam int CF_VTS   = 7;
  localparam int CF_CURVE = 8;
  localparam int CF_RMODE = 11;

  // reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PICKUP_RST = 16'h0064;
  localparam logic [15:0] TMULT_RST  = 16'h0064;
  localparam logic [15:0] RDELAY_RST = 16'h0000;
  localparam logic [15:0] VSEC_RST   = 16'h2710;

  // ---------------------------------------------------------------
  // characteristic constants
  // ---------------------------------------------------------------
  localparam logic [15:0] IN_1A       = 16'h0064;
  localparam logic [15:0] IN_5A       = 16'h01F4;
  localparam int          PICKUP_MIN_PCT = 2;
  localparam int          DYN_RANGE   = 40;
  localparam logic [1:0]  K_PHASE     = 2'h3;
  localparam logic [1:0]  K_GROUND    = 2'h1;
  localparam int          THERM_C_S   = 5;
  localparam logic [16:0] NOMV_LG_Q16 = 17'h093CD;
  localparam logic [16:0] SQRT3_2_Q16 = 17'h0DDB4;
  localparam logic [16:0] THIRD_Q16   = 17'h05555;
  localparam logic [5:0]  MULT [0:7]  = '{6'h02, 6'h03, 6'h04, 6'h06,
                                          6'h08, 6'h0C, 6'h14, 6'h28};
  // trip time in ms at unit multiplier, per inverse curve and multiple
  localparam logic [13:0] INV_MS [0:31] = '{
    14'h11AD, 14'h0F02, 14'h0DF3, 14'h0D09, 14'h0C9F, 14'h0C3C, 14'h0BF0, 14'h0BBA,
    14'h0EDB, 14'h0981, 14'h0799, 14'h05F6, 14'h052F, 14'h0465, 14'h03B4, 14'h0313,
    14'h1B74, 14'h0B7E, 14'h0706, 14'h041B, 14'h0322, 14'h0274, 14'h021C, 14'h01F7,
    14'h2532, 14'h0E3F, 14'h07D2, 14'h039F, 14'h0239, 14'h013F, 14'h00C0, 14'h008B};
  // reset time constant in ms at unit multiplier, per inverse curve
  localparam logic [14:0] TAU_MS [0:3] = '{15'h03E8, 15'h12F2, 15'h5460, 15'h71AC};

  typedef enum logic [2:0] {
    OTT_R_INVERSE_CURVE, OTT_MODERATE_INVERSE_CURVE, OTT_VERY_INVERSE_CURVE,
    OTT_EXTREME_INVERSE_CURVE, OTT_FLAT_THERMAL_CURVE, OTT_LINEAR_THERMAL_CURVE,
    OTT_SQUARE_THERMAL_CURVE, OTT_FOURTH_POWER_THERMAL_CURVE
  } ott_curve_t;

  typedef enum logic [1:0] {OTT_RST_CHAR, OTT_RST_DELAY, OTT_RST_INST} ott_rmode_t;
  typedef enum logic [1:0] {OTT_Q_PHASE, OTT_Q_NEGSEQ, OTT_Q_GROUND} ott_qty_t;

  typedef enum logic [3:0] {
    OTT_IDLE   = 4'b0001,
    OTT_TIMING = 4'b0010,
    OTT_TRIP   = 4'b0100,
    OTT_RESET  = 4'b1000
  } ott_state_t;

endpackage

//--- test/ott_meas_model.sv
// transformer side model: phase phasors, ground magnitude, voltages, breaker
// assumes the bench calls its tasks just after a rising edge of clk_i
module ott_meas_model (
  // clock
  input  wire logic          clk_i,
  // measured quantities towards the element
  output logic signed [15:0] ph_o [6],
  output logic        [15:0] ie_o,
  output logic        [15:0] vlg_o,
  output logic        [15:0] vll_o,
  output logic               mcb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] ph_n [6] = '{default: 16'h0000};
  logic        [15:0] ie_n = 16'h0000;
  logic        [15:0] vlg_n = 16'h0000;
  logic        [15:0] vll_n = 16'h0000;
  logic               mcb_n = 1'b0;
  // transformers refresh every sample, so values land on the next edge
  always @(posedge clk_i)
  begin
    ph_o <= ph_n;
    {ie_o, vlg_o, vll_o, mcb_o} <= {ie_n, vlg_n, vll_n, mcb_n};
  end
  task automatic set_i(input int ar, ai, br, bi, cr, ci, e);
    ph_n <= '{16'(ar), 16'(ai), 16'(br), 16'(bi), 16'(cr), 16'(ci)};
    ie_n <= 16'(e);
  endtask
  task automatic set_v(input int lg, ll, mc);
    {vlg_n, vll_n, mcb_n} <= {16'(lg), 16'(ll), 1'(mc)};
  endtask
endmodule

//--- test/tb_ott_overcurrent_trip_timing.sv
// self-checking bench for the overcurrent trip timing element
// assumes a 4-clock millisecond tick and the transformer model beside it
module tb_ott_overcurrent_trip_timing import ott_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam int TH_MS [4] = '{50, 75, 113, 254};
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic        [7:0]  wb_adr_i = 8'h00;
  logic        [3:0]  wb_sel_i = 4'h0;
  logic        [31:0] wb_dat_i = 32'h0;
  logic        [31:0] wb_dat_o;
  logic               wb_ack_o, pickup_o, trip_o, mcb;
  logic signed [15:0] ph [6];
  logic        [15:0] ie, vlg, vll;
  int                 bad_count = 0, n_checks = 0, cyc_n = 0;

  always #12.5 clk_i = ~clk_i;
  // a hung handshake or timer ends the run here
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  ott_meas_model ott_meas_model_i (.clk_i(clk_i), .ph_o(ph), .ie_o(ie), .vlg_o(vlg),
    .vll_o(vll), .mcb_o(mcb));
  ott_overcurrent_trip_timing #(.TICK_CYC(TK)) ott_overcurrent_trip_timing_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ia_re_i(ph[0]), .ia_im_i(ph[1]),
    .ib_re_i(ph[2]), .ib_im_i(ph[3]), .ic_re_i(ph[4]), .ic_im_i(ph[5]), .ie_mag_i(ie),
    .v_lg_i(vlg), .v_ll_i(vll), .mcb_trip_i(mcb), .pickup_o(pickup_o), .trip_o(trip_o));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, 16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic cur(input int a, e);
    ott_meas_model_i.set_i(a, 0, 0, 0, 0, 0, e);
  endtask
  // counts ms to trip, then checks status and the clear command
  task automatic meas(input int exp_ms);
    int n;
    logic [31:0] q;
    n = 0;
    while (trip_o !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("trip_ms_window", 32'(n / TK >= exp_ms - 3 && n / TK <= exp_ms + 3), 32'h1);
    wb(1'b0, OFS_STATUS, 16'h0000, q);
    chk("status_trip", q[1:0], 32'h3);
    wr(OFS_CMD, 16'h0001);
    cur(0, 0);
    repeat (2) @(posedge clk_i);
    chk("trip_cleared", trip_o, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic regs();
    logic [7:0]  ad [7] = '{OFS_CTRL, OFS_PICKUP, OFS_TMULT, OFS_RDELAY, OFS_VSEC, 8'h20,
                            OFS_PICKUP};
    logic [15:0] ex [7] = '{CTRL_RST, PICKUP_RST, TMULT_RST, RDELAY_RST, VSEC_RST, 16'h0000,
                            PICKUP_RST};
    logic [31:0] q;
    wr(8'h20, 16'h1234);
    // pickup below 0.02 In is refused
    wr(OFS_PICKUP, 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, ad[i], 16'h0000, q);
      chk("reg_read", q, {16'h0000, ex[i]});
    end
  endtask
  task automatic trip_time(input logic [15:0] ctl, input int a, e, exp_ms);
    wr(OFS_CTRL, ctl);
    cur(a, e);
    meas(exp_ms);
  endtask
  task automatic reset_mode(input int m, drop_ms, exp_ms);
    wr(OFS_CTRL, 16'h0401 | 16'(m << 11));
    cur(200, 0);
    repeat (30 * TK) @(posedge clk_i);
    cur(0, 0);
    repeat (drop_ms * TK) @(posedge clk_i);
    cur(200, 0);
    meas(exp_ms);
  endtask
  task automatic restr(input logic [15:0] ctl, input int lg, ll, mc, a, input logic exp);
    wr(OFS_CTRL, ctl);
    ott_meas_model_i.set_v(lg, ll, mc);
    cur(a, 0);
    repeat (6) @(posedge clk_i);
    chk("pickup_level", pickup_o, {31'h0, exp});
  endtask
  task automatic negseq(input logic [15:0] ctl, input logic exp);
    wr(OFS_CTRL, ctl);
    ott_meas_model_i.set_i(300, 0, -150, -260, -150, 260, 0);
    repeat (6) @(posedge clk_i);
    chk("balanced_pickup", pickup_o, {31'h0, exp});
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    regs();
    wr(OFS_TMULT, 16'h0001);
    wr(OFS_RDELAY, 16'h0014);
    // no inrush blocking, so short delays are allowed
    for (int i = 0; i < 4; i++)
      trip_time(16'h1001 | 16'(i << 8), 200, 0, int'(INV_MS[i * 8]) / 100);
    for (int i = 0; i < 4; i++)
      trip_time(16'h1401 | 16'(i << 8), 200, 0, TH_MS[i]);
    trip_time(16'h1505, 0, 200, 25);
    trip_time(16'h1503, 600, 0, 75);
    reset_mode(2, 5, 50);
    reset_mode(1, 5, 20);
    reset_mode(1, 30, 50);
    reset_mode(0, 5, 20);
    restr(16'h1421, 0, 0, 0, 50, 1'b0);
    restr(16'h1429, 0, 10000, 0, 50, 1'b0);
    restr(16'h1429, 0, 5500, 0, 60, 1'b1);
    restr(16'h1429, 0, 5500, 0, 50, 1'b0);
    restr(16'h1429, 10000, 0, 0, 50, 1'b1);
    restr(16'h14A9, 10000, 0, 1, 50, 1'b0);
    restr(16'h1409, 6000, 0, 0, 70, 1'b0);
    negseq(16'h1403, 1'b0);
    negseq(16'h1401, 1'b1);
    finish_test();
  end
endmodule
